// File: logic/sls_pkg.sv
/*
 Constants for the swing, load and directional supervision block:
 register byte offsets, control field positions, reset values,
 torque-control codes and timing figures.
 Assumes a 250 MHz core clock and a 1 ms protection tick.
*/
package sls_pkg;
   // Timing figures
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int MAX_BLOCK_S = 2;
   localparam int MAX_BLOCK_TICKS = MAX_BLOCK_S * 1000000 / TICK_PERIOD_US;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SWDLY = 8'h04;
   localparam logic [7:0] ADDR_Z5X = 8'h08;
   localparam logic [7:0] ADDR_Z5R = 8'h0c;
   localparam logic [7:0] ADDR_Z6X = 8'h10;
   localparam logic [7:0] ADDR_Z6R = 8'h14;
   localparam logic [7:0] ADDR_LOUT = 8'h18;
   localparam logic [7:0] ADDR_LIN = 8'h1c;
   localparam logic [7:0] ADDR_LANG = 8'h20;
   localparam logic [7:0] ADDR_REACH = 8'h24;
   localparam logic [7:0] ADDR_QTHR = 8'h28;
   localparam logic [7:0] ADDR_RATIO = 8'h2c;
   localparam logic [7:0] ADDR_PTOC = 8'h30;
   localparam logic [7:0] ADDR_NTOC = 8'h34;
   localparam logic [7:0] ADDR_QTOC = 8'h38;
   localparam logic [7:0] ADDR_STATUS = 8'h3c;
   localparam int NUM_RW = 15;
   // Control register fields
   localparam int CTRL_SWB_LSB = 0;
   localparam int CTRL_LE_BIT = 4;
   localparam int CTRL_LOPF_BIT = 5;
   localparam int CTRL_EN_LSB = 6;
   localparam int CTRL_IEC_LSB = 9;
   localparam int CTRL_SLOW_LSB = 12;
   localparam int CTRL_TQP_LSB = 15;
   localparam int CTRL_TQN_LSB = 18;
   localparam int CTRL_TQQ_LSB = 21;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // Torque-control codes
   localparam logic [2:0] TQ_NONDIR = 3'h0;
   localparam logic [2:0] TQ_M2P = 3'h1;
   localparam logic [2:0] TQ_Z2G = 3'h2;
   localparam logic [2:0] TQ_FWD = 3'h3;
   localparam logic [2:0] TQ_REV = 3'h4;
   // Curve scale per time-dial step
   localparam int US_SHIFT = 4;
   localparam int IEC_SHIFT = 5;
endpackage

// File: logic/sls_rect_zone.sv
/*
 Rectangular impedance-plane comparator for one swing zone.
 Assumes signed resistance and reactance on a common scale.
*/
`timescale 1ns/100ps
module sls_rect_zone #(
   parameter int W = 16
) (
   input wire logic signed [W-1:0] r_i,
   input wire logic signed [W-1:0] x_i,
   input wire logic signed [W-1:0] top_i,
   input wire logic signed [W-1:0] bottom_i,
   input wire logic signed [W-1:0] right_i,
   input wire logic signed [W-1:0] left_i,
   output logic inside_o
);
   // Inside when bounded on all four sides
   assign inside_o = (x_i <= top_i) && (x_i >= bottom_i) && (r_i <= right_i) && (r_i >= left_i);
endmodule

// File: logic/sls_toc_elem.sv
/*
 One time-overcurrent element: pickup, accumulated curve time and
 fast or slow reset. Assumes a one-cycle tick pulse per time step.
*/
`timescale 1ns/100ps
module sls_toc_elem #(
   parameter int W = 16,
   parameter int AW = 24
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic enable_i,
   input wire logic torque_i,
   input wire logic [W-1:0] current_i,
   input wire logic [W-1:0] pickup_i,
   input wire logic [W-1:0] dial_i,
   input wire logic iec_i,
   input wire logic slow_i,
   output logic pickup_o,
   output logic timed_out_o,
   output logic resetting_o
);
   import sls_pkg::*;
   logic [AW-1:0] acc_ff;
   logic [AW-1:0] limit;
   logic picked;

   // Curve equations live upstream; the dial scales a per-family limit
   assign limit = iec_i ? (AW'(dial_i) << IEC_SHIFT) : (AW'(dial_i) << US_SHIFT);
   assign picked = enable_i && torque_i && (current_i > pickup_i);

   // Accumulate while picked up, decay or clear otherwise
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_ff <= '0;
      end else if (picked) begin
         if (tick_i && acc_ff < limit) begin
            acc_ff <= acc_ff + 1'b1;
         end
      end else if (!slow_i) begin
         acc_ff <= '0; // Fast reset well inside one power cycle
      end else if (tick_i && acc_ff != '0) begin
         acc_ff <= acc_ff - 1'b1; // Disk-like decay
      end
   end

   // Element flags
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pickup_o <= 1'b0;
         timed_out_o <= 1'b0;
         resetting_o <= 1'b0;
      end else begin
         pickup_o <= picked;
         timed_out_o <= picked && (acc_ff >= limit);
         resetting_o <= !picked && slow_i && (acc_ff != '0);
      end
   end
endmodule

// File: logic/sls_top.sv
/*
 Swing blocking and tripping, load-encroachment blocking, negative-
 sequence directional decisions and time-overcurrent elements, with
 an APB register file. Assumes upstream measurement delivers
 magnitudes, impedances and comparator flags synchronous to MCLK_I.
*/
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module sls_top
   import sls_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int W = 16
) (
   input wire logic MCLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic signed [W-1:0] POS_R_I,
   input wire logic signed [W-1:0] POS_X_I,
   input wire logic [W-1:0] POS_ZMAG_I,
   input wire logic [8:0] POS_ANG_I,
   input wire logic signed [W-1:0] NEG_Z_I,
   input wire logic [W-1:0] I1_MAG_I,
   input wire logic [W-1:0] I2X3_MAG_I,
   input wire logic [W-1:0] IPH_MAX_I,
   input wire logic [W-1:0] IRES_I,
   input wire logic THREE_PHASE_OC_SUPERVISION_I,
   input wire logic [3:0] NEGSEQ_OC_LEVEL_I,
   input wire logic RESIDUAL_OC_LEVEL1_I,
   input wire logic POTENTIAL_LOST_I,
   input wire logic ZONE2_PHASE_MHO_I,
   input wire logic ZONE2_GROUND_DISTANCE_I,
   input wire logic [3:0] PH3_DIST_I,
   input wire logic [3:0] PHPH_DIST_I,
   input wire logic [3:0] GND_DIST_I,
   output logic OUTER_SWING_ZONE_FLAG_O,
   output logic INNER_SWING_ZONE_FLAG_O,
   output logic SWING_OC_FLAG_O,
   output logic SWING_BLOCK_CONDITION_O,
   output logic [3:0] ZONE_SWING_BLOCKED_O,
   output logic SWING_TRIP_INITIATED_O,
   output logic SWING_TRIP_CONDITION_O,
   output logic LOAD_ELEMENT_O,
   output logic [3:0] PHASE_DIST_O,
   output logic [3:0] GND_DIST_O,
   output logic FORWARD_UNBALANCED_DIR_O,
   output logic REVERSE_UNBALANCED_DIR_O,
   output logic NEGSEQ_SUPERVISION_ANY_O,
   output logic RESIDUAL_DIR_LEVEL1_O,
   output logic NEGSEQ_DIR_LEVEL1_O,
   output logic [2:0] TOC_PICKUP_O,
   output logic [2:0] TOC_TIMED_OUT_O,
   output logic [2:0] TOC_RESETTING_O
);
   import sls_pkg::*;

   typedef enum logic [1:0] {SW_IDLE, SW_TIMING, SW_BLOCK, SW_TRIP} sls_swing_t;

   logic [31:0] reg_ff [NUM_RW];
   logic [3:0] idx;
   logic mapped;
   logic access;
   logic wr_en;
   logic [31:0] status;
   logic [31:0] rd_mux;
   logic [$clog2(TICK_CYC+1)-1:0] tick_cnt_ff;
   logic tick_ff;
   sls_swing_t sw_ff;
   sls_swing_t nxt_sw;
   logic [15:0] dwell_ff;
   logic [15:0] nxt_dwell;
   logic [15:0] hold_ff;
   logic in5;
   logic in6;
   logic outer;
   logic inner;
   logic blk;
   logic trip_pulse;
   logic [3:0] zone_blk;
   logic signed [9:0] sang;
   logic ld_out;
   logic ld_in;
   logic load;
   logic q_fwd;
   logic q_rev;
   logic restr_ok;
   logic fwd;
   logic rev;
   logic [2:0] tq_sel [3];
   logic [2:0] torque;
   logic [W-1:0] toc_cur [3];
   logic [31:0] ctrl;

   // APB decode: word aligned, status is the last word and read-only
   assign idx = PADDR_I[5:2];
   assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I[7:6] == 2'h0) && !(PWRITE_I && PADDR_I == ADDR_STATUS);
   assign access = PSEL_I && PENABLE_I && !PREADY_O;
   assign wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && mapped;
   assign ctrl = reg_ff[ADDR_CTRL[5:2]];

   // One wait state keeps PRDATA and PSLVERR registered
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
      end else begin
         PREADY_O <= access;
         PSLVERR_O <= access && !mapped;
         if (access) begin
            PRDATA_O <= (mapped && !PWRITE_I) ? rd_mux : 32'h0000_0000;
         end
      end
   end

   // Read data select
   always_comb begin
      if (PADDR_I == ADDR_STATUS) begin
         rd_mux = status;
      end else begin
         rd_mux = reg_ff[idx];
      end
   end

   // Settings store; writes land at the edge that completes the access
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         for (int i = 0; i < NUM_RW; i++) begin
            reg_ff[i] <= REG_RST;
         end
      end else if (wr_en) begin
         reg_ff[idx] <= PWDATA_I;
      end
   end

   // Protection time base: one pulse per millisecond
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (tick_cnt_ff == TICK_CYC - 1);
         if (tick_cnt_ff == TICK_CYC - 1) begin
            tick_cnt_ff <= '0;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
         end
      end
   end

   // Swing zones on the positive-sequence plane
   sls_rect_zone #(.W(W)) u_zone5 (
      .r_i(POS_R_I),
      .x_i(POS_X_I),
      .top_i(reg_ff[ADDR_Z5X[5:2]][15:0]),
      .bottom_i(reg_ff[ADDR_Z5X[5:2]][31:16]),
      .right_i(reg_ff[ADDR_Z5R[5:2]][15:0]),
      .left_i(reg_ff[ADDR_Z5R[5:2]][31:16]),
      .inside_o(in5)
   );
   sls_rect_zone #(.W(W)) u_zone6 (
      .r_i(POS_R_I),
      .x_i(POS_X_I),
      .top_i(reg_ff[ADDR_Z6X[5:2]][15:0]),
      .bottom_i(reg_ff[ADDR_Z6X[5:2]][31:16]),
      .right_i(reg_ff[ADDR_Z6R[5:2]][15:0]),
      .left_i(reg_ff[ADDR_Z6R[5:2]][31:16]),
      .inside_o(in6)
   );
   assign outer = in5 && THREE_PHASE_OC_SUPERVISION_I;
   assign inner = in6 && THREE_PHASE_OC_SUPERVISION_I;

   // Swing sequence: dwell between zones, then block, then trip arming
   always_comb begin
      nxt_sw = sw_ff;
      nxt_dwell = dwell_ff;
      trip_pulse = 1'b0;
      unique case (sw_ff)
         SW_IDLE: begin
            nxt_dwell = '0;
            if (outer && !inner) begin
               nxt_sw = SW_TIMING;
            end
         end
         SW_TIMING: begin
            if (!outer || inner) begin
               nxt_sw = SW_IDLE;
            end else if (dwell_ff > reg_ff[ADDR_SWDLY[5:2]][15:0]) begin
               nxt_sw = SW_BLOCK;
               nxt_dwell = '0;
            end else if (tick_ff) begin
               nxt_dwell = dwell_ff + 1'b1;
            end
         end
         SW_BLOCK: begin
            if (!outer || hold_ff >= 16'(MAX_BLOCK_TICKS)) begin
               nxt_sw = SW_IDLE;
            end else if (!inner) begin
               nxt_dwell = '0;
            end else if (dwell_ff >= reg_ff[ADDR_SWDLY[5:2]][31:16]) begin
               nxt_sw = SW_TRIP;
            end else if (tick_ff) begin
               nxt_dwell = dwell_ff + 1'b1;
            end
         end
         SW_TRIP: begin
            if (!outer) begin
               nxt_sw = SW_IDLE;
               trip_pulse = 1'b1;
            end else if (hold_ff >= 16'(MAX_BLOCK_TICKS)) begin
               nxt_sw = SW_IDLE;
            end
         end
      endcase
   end

   // Swing state and dwell counter
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         sw_ff <= SW_IDLE;
         dwell_ff <= '0;
      end else begin
         sw_ff <= nxt_sw;
         dwell_ff <= nxt_dwell;
      end
   end

   // Block length bound, counted from entry into blocking
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         hold_ff <= '0;
      end else if (sw_ff != SW_BLOCK && sw_ff != SW_TRIP) begin
         hold_ff <= '0;
      end else if (tick_ff) begin
         hold_ff <= hold_ff + 1'b1;
      end
   end

   assign blk = (sw_ff == SW_BLOCK) || (sw_ff == SW_TRIP);
   // Enabled zones only; an unbalanced level lifts its own zone
   assign zone_blk = {4{blk}} & ctrl[CTRL_SWB_LSB +: 4] & ~NEGSEQ_OC_LEVEL_I;

   // Load regions: signed angle for the outgoing side
   assign sang = (POS_ANG_I >= 9'd180) ? (10'(POS_ANG_I) - 10'sd360) : 10'(POS_ANG_I);
   assign ld_out = (POS_ZMAG_I >= reg_ff[ADDR_LOUT[5:2]][15:0])
      && (sang <= 10'(signed'(reg_ff[ADDR_LOUT[5:2]][23:16])))
      && (sang >= 10'(signed'(reg_ff[ADDR_LOUT[5:2]][31:24])));
   assign ld_in = (POS_ZMAG_I >= reg_ff[ADDR_LIN[5:2]][15:0])
      && (POS_ANG_I >= reg_ff[ADDR_LANG[5:2]][8:0])
      && (POS_ANG_I <= reg_ff[ADDR_LANG[5:2]][24:16]);
   assign load = ctrl[CTRL_LE_BIT] && (ld_out || ld_in);

   // Negative-sequence decisions; the input is 3I2, so the restraint side is tripled (1/256 steps)
   assign q_fwd = I2X3_MAG_I > reg_ff[ADDR_QTHR[5:2]][15:0];
   assign q_rev = I2X3_MAG_I > reg_ff[ADDR_QTHR[5:2]][31:16];
   assign restr_ok = 26'({I2X3_MAG_I, 8'h00}) > (26'(I1_MAG_I) * 26'(reg_ff[ADDR_RATIO[5:2]][7:0]) * 26'd3);
   always_comb begin
      if (POTENTIAL_LOST_I) begin
         fwd = ctrl[CTRL_LOPF_BIT] && q_fwd && restr_ok;
         rev = 1'b0;
      end else begin
         fwd = restr_ok && q_fwd && (NEG_Z_I <= signed'(reg_ff[ADDR_REACH[5:2]][15:0]));
         rev = restr_ok && q_rev && (NEG_Z_I >= signed'(reg_ff[ADDR_REACH[5:2]][31:16]));
      end
   end

   // Torque selection; an option not offered to an element holds it off
   assign tq_sel[0] = ctrl[CTRL_TQP_LSB +: 3];
   assign tq_sel[1] = ctrl[CTRL_TQN_LSB +: 3];
   assign tq_sel[2] = ctrl[CTRL_TQQ_LSB +: 3];
   always_comb begin
      torque = 3'h0;
      unique case (tq_sel[0])
         TQ_NONDIR: torque[0] = 1'b1;
         TQ_M2P: torque[0] = ZONE2_PHASE_MHO_I;
         default: torque[0] = 1'b0;
      endcase
      unique case (tq_sel[1])
         TQ_NONDIR: torque[1] = 1'b1;
         TQ_Z2G: torque[1] = ZONE2_GROUND_DISTANCE_I;
         TQ_FWD: torque[1] = fwd;
         TQ_REV: torque[1] = rev;
         default: torque[1] = 1'b0;
      endcase
      unique case (tq_sel[2])
         TQ_NONDIR: torque[2] = 1'b1;
         TQ_M2P: torque[2] = ZONE2_PHASE_MHO_I;
         TQ_Z2G: torque[2] = ZONE2_GROUND_DISTANCE_I;
         TQ_FWD: torque[2] = fwd;
         TQ_REV: torque[2] = rev;
         default: torque[2] = 1'b0;
      endcase
   end

   // Operating quantities per element
   assign toc_cur[0] = IPH_MAX_I;
   assign toc_cur[1] = IRES_I;
   assign toc_cur[2] = I2X3_MAG_I;

   // Phase, residual and negative-sequence time-overcurrent
   for (genvar g = 0; g < 3; g++) begin : g_toc
      sls_toc_elem #(.W(W)) u_toc (
         .clk_i(MCLK_I),
         .rst_n_i(RSTN_I),
         .tick_i(tick_ff),
         .enable_i(ctrl[CTRL_EN_LSB + g]),
         .torque_i(torque[g]),
         .current_i(toc_cur[g]),
         .pickup_i(reg_ff[ADDR_PTOC[5:2] + 4'(g)][15:0]),
         .dial_i(reg_ff[ADDR_PTOC[5:2] + 4'(g)][31:16]),
         .iec_i(ctrl[CTRL_IEC_LSB + g]),
         .slow_i(ctrl[CTRL_SLOW_LSB + g]),
         .pickup_o(TOC_PICKUP_O[g]),
         .timed_out_o(TOC_TIMED_OUT_O[g]),
         .resetting_o(TOC_RESETTING_O[g])
      );
   end

   // Swing flags, registered for the trip logic
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         OUTER_SWING_ZONE_FLAG_O <= 1'b0;
         INNER_SWING_ZONE_FLAG_O <= 1'b0;
         SWING_OC_FLAG_O <= 1'b0;
         SWING_BLOCK_CONDITION_O <= 1'b0;
         ZONE_SWING_BLOCKED_O <= 4'h0;
         SWING_TRIP_INITIATED_O <= 1'b0;
         SWING_TRIP_CONDITION_O <= 1'b0;
      end else begin
         OUTER_SWING_ZONE_FLAG_O <= outer;
         INNER_SWING_ZONE_FLAG_O <= inner;
         SWING_OC_FLAG_O <= THREE_PHASE_OC_SUPERVISION_I;
         SWING_BLOCK_CONDITION_O <= blk;
         ZONE_SWING_BLOCKED_O <= zone_blk;
         SWING_TRIP_INITIATED_O <= (sw_ff == SW_TRIP);
         SWING_TRIP_CONDITION_O <= trip_pulse;
      end
   end

   // Distance and directional outputs
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         LOAD_ELEMENT_O <= 1'b0;
         PHASE_DIST_O <= 4'h0;
         GND_DIST_O <= 4'h0;
         FORWARD_UNBALANCED_DIR_O <= 1'b0;
         REVERSE_UNBALANCED_DIR_O <= 1'b0;
         NEGSEQ_SUPERVISION_ANY_O <= 1'b0;
         RESIDUAL_DIR_LEVEL1_O <= 1'b0;
         NEGSEQ_DIR_LEVEL1_O <= 1'b0;
      end else begin
         LOAD_ELEMENT_O <= load;
         // Balanced elements see load blocking, unbalanced see direction
         PHASE_DIST_O <= ((PH3_DIST_I & {4{!load}}) | (PHPH_DIST_I & {4{fwd}})) & ~zone_blk;
         // Ground elements bypass the swing logic entirely
         GND_DIST_O <= GND_DIST_I & {4{fwd}};
         FORWARD_UNBALANCED_DIR_O <= fwd;
         REVERSE_UNBALANCED_DIR_O <= rev;
         NEGSEQ_SUPERVISION_ANY_O <= q_fwd || q_rev;
         RESIDUAL_DIR_LEVEL1_O <= RESIDUAL_OC_LEVEL1_I && fwd;
         NEGSEQ_DIR_LEVEL1_O <= NEGSEQ_OC_LEVEL_I[0] && fwd;
      end
   end

   // Status word mirrors the live decisions
   assign status = {9'h000, TOC_RESETTING_O, TOC_TIMED_OUT_O, TOC_PICKUP_O,
      NEGSEQ_SUPERVISION_ANY_O, REVERSE_UNBALANCED_DIR_O, FORWARD_UNBALANCED_DIR_O,
      LOAD_ELEMENT_O, SWING_TRIP_CONDITION_O, SWING_TRIP_INITIATED_O,
      SWING_BLOCK_CONDITION_O, SWING_OC_FLAG_O, INNER_SWING_ZONE_FLAG_O,
      OUTER_SWING_ZONE_FLAG_O, ZONE_SWING_BLOCKED_O};
endmodule

// File: test/sls_top_chk.sv
/*
 Port checker for the supervision block: APB answer timing, swing flags and directional outputs.
 Assumes it is bound to sls_top and sees only that module's ports.
*/
`timescale 1ns/100ps
module sls_top_chk
   import sls_pkg::*;
#(
   parameter int TICK_CYC = 4
) (
   input wire logic MCLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic POTENTIAL_LOST_I,
   input wire logic [3:0] NEGSEQ_OC_LEVEL_I,
   input wire logic [3:0] ZONE_SWING_BLOCKED_O,
   input wire logic SWING_BLOCK_CONDITION_O,
   input wire logic SWING_TRIP_INITIATED_O,
   input wire logic SWING_TRIP_CONDITION_O,
   input wire logic FORWARD_UNBALANCED_DIR_O,
   input wire logic REVERSE_UNBALANCED_DIR_O,
   input wire logic NEGSEQ_SUPERVISION_ANY_O
);
   // Slack of two ticks covers the tick phase at block entry
   localparam int BLK_LIM = (MAX_BLOCK_TICKS + 2) * TICK_CYC;
   int blk_cnt_ff;
   default clocking dcb @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);
   sequence s_wait;
      PSEL_I && PENABLE_I && !PREADY_O;
   endsequence
   sequence s_answer;
      PREADY_O ##1 !PREADY_O;
   endsequence
   // Length of the current blocking run
   always_ff @(posedge MCLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         blk_cnt_ff <= 0;
      end else begin
         blk_cnt_ff <= SWING_BLOCK_CONDITION_O ? blk_cnt_ff + 1 : 0;
      end
   end
   a_apb_one_wait: assert property (s_wait |=> s_answer) else $error("apb answer not after one wait");
   a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("slave error without ready");
   a_block_limit: assert property (blk_cnt_ff <= BLK_LIM) else $error("swing block too long");
   a_zone_needs_block: assert property (|ZONE_SWING_BLOCKED_O |-> SWING_BLOCK_CONDITION_O)
      else $error("zone blocked without block condition");
   a_level_unblocks: assert property ((ZONE_SWING_BLOCKED_O & $past(NEGSEQ_OC_LEVEL_I)) == 4'h0)
      else $error("zone blocked despite negative-sequence level");
   a_trip_pulse: assert property (SWING_TRIP_CONDITION_O |=> !SWING_TRIP_CONDITION_O)
      else $error("trip condition longer than one cycle");
   a_trip_after_init: assert property ($rose(SWING_TRIP_CONDITION_O) |-> $past(SWING_TRIP_INITIATED_O))
      else $error("trip condition without trip initiated");
   a_lop_no_rev: assert property (POTENTIAL_LOST_I |=> !REVERSE_UNBALANCED_DIR_O)
      else $error("reverse asserted on lost potential");
   a_dir_needs_sup: assert property (FORWARD_UNBALANCED_DIR_O || REVERSE_UNBALANCED_DIR_O |->
      NEGSEQ_SUPERVISION_ANY_O) else $error("direction without supervision flag");
endmodule

// File: test/sls_meas_model.sv
/*
 Upstream measurement model: a scene code becomes positive-sequence resistance, reactance and the
 three-phase overcurrent flag. Assumes the bench changes the scene right after a clock edge.
*/
`timescale 1ns/100ps
module sls_meas_model (
   input wire logic [1:0] scene_i,
   output logic signed [15:0] r_o,
   output logic signed [15:0] x_o,
   output logic oc_o
);
   // Scene 0 far away, 1 between zones, 2 inside the inner zone, 3 between without current
   localparam logic [15:0] R_TAB [4] = '{16'h7000, 16'h012c, 16'h000a, 16'h012c};
   // Reactance stays small so only resistance walks the point through the zones
   assign r_o = R_TAB[scene_i];
   assign x_o = 16'sh0005;
   assign oc_o = scene_i[0] ^ scene_i[1];
endmodule

// File: test/tb_swing_load_directional_supervision.sv
/*
 Self-checking bench for sls_top: APB register access, swing, load, directional and TOC paths.
 Assumes sls_pkg, the measurement model and the checker are compiled first.
*/
`timescale 1ns/100ps
module tb_swing_load_directional_supervision;
   import sls_pkg::*;
   logic MCLK_I = 1'b0, RSTN_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
   logic [7:0] PADDR_I = 8'h00;
   logic [31:0] PWDATA_I = 32'h0, PRDATA_O, seed = 32'h0000_0036;
   logic PREADY_O, PSLVERR_O, THREE_PHASE_OC_SUPERVISION_I, RESIDUAL_OC_LEVEL1_I = 1'b1;
   logic POTENTIAL_LOST_I = 1'b0, ZONE2_PHASE_MHO_I = 1'b0, ZONE2_GROUND_DISTANCE_I = 1'b0;
   logic [1:0] scene = 2'h0;
   logic signed [15:0] POS_R_I, POS_X_I, NEG_Z_I = 16'sh0;
   logic [15:0] POS_ZMAG_I = 16'h0, I1_MAG_I = 16'h0, I2X3_MAG_I = 16'h0, IPH_MAX_I = 16'h0, IRES_I = 16'h1;
   logic [8:0] POS_ANG_I = 9'h0;
   logic [3:0] NEGSEQ_OC_LEVEL_I = 4'h0, PH3_DIST_I = 4'h0, PHPH_DIST_I = 4'he, GND_DIST_I = 4'h0;
   logic OUTER_SWING_ZONE_FLAG_O, INNER_SWING_ZONE_FLAG_O, SWING_OC_FLAG_O, SWING_BLOCK_CONDITION_O;
   logic SWING_TRIP_INITIATED_O, SWING_TRIP_CONDITION_O, LOAD_ELEMENT_O, FORWARD_UNBALANCED_DIR_O;
   logic REVERSE_UNBALANCED_DIR_O, NEGSEQ_SUPERVISION_ANY_O, RESIDUAL_DIR_LEVEL1_O, NEGSEQ_DIR_LEVEL1_O;
   logic [3:0] ZONE_SWING_BLOCKED_O, PHASE_DIST_O, GND_DIST_O;
   logic [2:0] TOC_PICKUP_O, TOC_TIMED_OUT_O, TOC_RESETTING_O;
   logic [32:0] expq [$];
   logic [32:0] ex;
   int n_errors = 0, compares = 0, cyc = 0;
   wire [7:0] fl = {TOC_RESETTING_O[0], TOC_TIMED_OUT_O[0], TOC_PICKUP_O[0], LOAD_ELEMENT_O,
      SWING_TRIP_CONDITION_O, SWING_TRIP_INITIATED_O, SWING_BLOCK_CONDITION_O, PHASE_DIST_O[0]};
   // Rows: expected load and zone-1 phase distance, |Z|, angle
   localparam logic [26:0] LT [5] = '{{2'b10, 16'h00c8, 9'h00a}, {2'b10, 16'h00c8, 9'h0b4},
      {2'b01, 16'h00c8, 9'h05a}, {2'b01, 16'h0032, 9'h00a}, {2'b10, 16'h00c8, 9'h15e}};
   // Rows: lost potential, negative-sequence reactance, I1, 3I2, expected forward, reverse, any
   localparam logic [51:0] DT [5] = '{{1'b0, 16'hfffb, 16'h0064, 16'h0064, 3'b101},
      {1'b0, 16'h00c8, 16'h0064, 16'h0064, 3'b011}, {1'b0, 16'hfffb, 16'h012c, 16'h0064, 3'b001},
      {1'b1, 16'h00c8, 16'h0064, 16'h0064, 3'b101}, {1'b1, 16'h00c8, 16'h0064, 16'h0005, 3'b000}};

   sls_top #(.TICK_CYC(4)) dut (.*);
   sls_meas_model u_meas (.scene_i(scene), .r_o(POS_R_I), .x_o(POS_X_I), .oc_o(THREE_PHASE_OC_SUPERVISION_I));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // One APB transfer; the expected error flag and read data go on the queue
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      expq.push_back(e);
      PSEL_I <= 1'b1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge MCLK_I);
      PENABLE_I <= 1'b1;
      do @(posedge MCLK_I); while (PREADY_O !== 1'b1);
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
      @(posedge MCLK_I);
   endtask

   // Bounded wait for one flag to reach a level; a miss shows up as a mismatch
   task automatic wt(input string nm, input int i, input logic v, input int lim);
      int t;
      t = 0;
      while (fl[i] !== v && t < lim) begin
         @(posedge MCLK_I);
         t++;
      end
      chk(nm, fl[i], v);
   endtask

   initial forever #2 MCLK_I = ~MCLK_I;

   // Completed transfers are compared with the oldest note; the cycle ceiling cuts a hang
   always @(posedge MCLK_I) begin
      cyc++;
      if (PSEL_I && PENABLE_I && PREADY_O === 1'b1) begin
         ex = expq.pop_front();
         chk("pslverr", PSLVERR_O, ex[32]);
         if (!PWRITE_I) begin
            chk("prdata", PRDATA_O, ex[31:0]);
         end
      end
      if (cyc == 30000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (3) @(posedge MCLK_I);
      RSTN_I <= 1'b1;
      @(posedge MCLK_I);
      // Reset value, refused places, random readback
      apb(1'b0, ADDR_STATUS, 32'h0, {1'b0, REG_RST});
      apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
      apb(1'b1, ADDR_STATUS, 32'hffff_ffff, {1'b1, 32'h0});
      for (int i = 1; i < 7; i++) begin
         repeat (9) seed = lfsr(seed);
         GND_DIST_I <= seed[3:0];
         apb(1'b1, 8'(i * 4), seed, 33'h0);
         apb(1'b0, 8'(i * 4), 32'h0, {1'b0, seed});
      end
      // Swing: level 2 present, all four zones enabled, two-tick delays
      apb(1'b1, ADDR_Z5X, 32'hfc00_0400, 33'h0);
      apb(1'b1, ADDR_Z5R, 32'hfc00_0400, 33'h0);
      apb(1'b1, ADDR_Z6X, 32'hff9c_0064, 33'h0);
      apb(1'b1, ADDR_Z6R, 32'hff9c_0064, 33'h0);
      apb(1'b1, ADDR_SWDLY, 32'h0002_0002, 33'h0);
      apb(1'b1, ADDR_CTRL, 32'h0000_000f, 33'h0);
      NEGSEQ_OC_LEVEL_I <= 4'h2;
      scene <= 2'h1;
      wt("swing block", 1, 1'b1, 40);
      chk("zone flags", {OUTER_SWING_ZONE_FLAG_O, INNER_SWING_ZONE_FLAG_O, SWING_OC_FLAG_O}, 3'b101);
      chk("zones blocked", ZONE_SWING_BLOCKED_O, 4'hd);
      repeat (7900) @(posedge MCLK_I);
      chk("block held", SWING_BLOCK_CONDITION_O, 1'b1);
      wt("block ends", 1, 1'b0, 200);
      wt("reblock", 1, 1'b1, 40);
      scene <= 2'h2;
      wt("trip armed", 2, 1'b1, 60);
      scene <= 2'h0;
      wt("trip pulse", 3, 1'b1, 10);
      // Load regions with the loss-of-potential forward default set
      NEGSEQ_OC_LEVEL_I <= 4'h1;
      PH3_DIST_I <= 4'h1;
      apb(1'b1, ADDR_LOUT, 32'hd32d_0064, 33'h0);
      apb(1'b1, ADDR_LIN, 32'h0000_0064, 33'h0);
      apb(1'b1, ADDR_LANG, 32'h00e1_0087, 33'h0);
      apb(1'b1, ADDR_CTRL, 32'h008c_01b0, 33'h0);
      foreach (LT[k]) begin
         {POS_ZMAG_I, POS_ANG_I} <= LT[k][24:0];
         repeat (3) @(posedge MCLK_I);
         chk("load", {LOAD_ELEMENT_O, PHASE_DIST_O[0]}, LT[k][26:25]);
      end
      // Directional decisions
      apb(1'b1, ADDR_REACH, 32'h0064_0000, 33'h0);
      apb(1'b1, ADDR_QTHR, 32'h000a_000a, 33'h0);
      apb(1'b1, ADDR_RATIO, 32'h0000_0040, 33'h0);
      foreach (DT[k]) begin
         {POTENTIAL_LOST_I, NEG_Z_I, I1_MAG_I, I2X3_MAG_I} <= DT[k][51:3];
         repeat (3) @(posedge MCLK_I);
         chk("direction", {FORWARD_UNBALANCED_DIR_O, REVERSE_UNBALANCED_DIR_O, NEGSEQ_SUPERVISION_ANY_O,
            RESIDUAL_DIR_LEVEL1_O, NEGSEQ_DIR_LEVEL1_O, GND_DIST_O, PHASE_DIST_O, TOC_PICKUP_O[2:1]},
            {DT[k][2:0], {2{DT[k][2]}}, GND_DIST_I & {4{DT[k][2]}},
            4'he & {4{DT[k][2]}}, DT[k][1], DT[k][2]});
      end
      // Phase TOC, dial 1 US is 16 ticks; fast then slow reset
      POTENTIAL_LOST_I <= 1'b0;
      apb(1'b1, ADDR_PTOC, 32'h0001_0032, 33'h0);
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, ADDR_CTRL, (m == 1) ? 32'h0000_1040 : 32'h0000_0040, 33'h0);
         IPH_MAX_I <= 16'h0064;
         wt("toc pickup", 5, 1'b1, 4);
         repeat (40) @(posedge MCLK_I);
         chk("toc early", {TOC_TIMED_OUT_O, TOC_PICKUP_O[2:1]}, 5'h00);
         wt("toc timed", 6, 1'b1, 40);
         IPH_MAX_I <= 16'h0000;
         repeat (3) @(posedge MCLK_I);
         chk("toc resetting", TOC_RESETTING_O[0], m == 1);
         repeat (90) @(posedge MCLK_I);
      end
      tally_and_finish();
   end
endmodule

bind sls_top sls_top_chk #(.TICK_CYC(TICK_CYC)) u_chk (.*);
